/* verilog/bmsg_pkg.sv */
// Package: constants and types of the buzzer melody sound generator
`default_nettype none

package bmsg_pkg;

	// Clock rates; the sound clock is an enable pulse divided from CLK
	localparam int unsigned CLK_HZ       = 25000000;
	localparam int unsigned SND_HZ       = 32768;
	localparam int unsigned SND_DIV      = CLK_HZ / SND_HZ;
	localparam int unsigned DIV_W        = 10;

	// Register byte addresses
	localparam logic [7:0]  ADR_MODE     = 8'h00;
	localparam logic [7:0]  ADR_BUF      = 8'h04;
	localparam logic [7:0]  ADR_FLAG     = 8'h08;
	localparam logic [7:0]  ADR_DMA      = 8'h0C;

	// Field positions
	localparam int unsigned MODE_LSB     = 0;
	localparam int unsigned DUR_LSB      = 4;
	localparam int unsigned FLG_EMPTY    = 0;
	localparam int unsigned FLG_DONE     = 1;
	localparam int unsigned FLG_BUSY     = 2;

	// Output mode select codes
	localparam logic [1:0]  MODE_ONESHOT = 2'h1;
	localparam logic [1:0]  MODE_MELODY  = 2'h2;

	// Timing in sound clock ticks
	localparam int unsigned ONESHOT_BASE = 256;
	localparam int unsigned TEMPO_BASE   = 64;
	localparam logic [4:0]  GAP_TICKS    = 5'h10;
	localparam int unsigned TMR_W        = 20;

	// Reset values and DMA channel count
	localparam logic        RST_EMPTY    = 1'b1;
	localparam logic [1:0]  RST_MODE     = 2'h0;
	localparam int unsigned DMA_CH       = 4;

	typedef struct packed {
		logic       tie_slur_bit;
		logic       rest_select_bit;
		logic [5:0] pulse_length;
		logic [7:0] freq_period;
	} bmsg_word_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_PLAY = 1'b1
	} bmsg_state_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       out;
	} bmsg_pwm_st_t;

	typedef struct packed {
		bmsg_state_t         state;
		logic [1:0]          output_mode_sel;
		logic [3:0]          duration_tempo_sel;
		bmsg_word_t          sound_buffer;
		logic                buf_full;
		bmsg_word_t          sound_reg;
		logic                buffer_empty_flag;
		logic                output_done_flag;
		logic [DMA_CH-1:0]   empty_dma_enable_bit;
		logic [DIV_W-1:0]    div;
		logic [TMR_W-1:0]    tmr;
		logic [4:0]          gap;
		logic [15:0]         rdata;
		logic [DMA_CH-1:0]   dma_req;
		logic                bz;
	} bmsg_st_t;

endpackage

`default_nettype wire

/* verilog/bmsg_pwm.sv */
// Tone waveform generator: period and pulse length in sound clock ticks
`timescale 1ns/1ps
`default_nettype none

module bmsg_pwm (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       tick,
	input  wire logic       run,
	input  wire logic [7:0] period,
	input  wire logic [5:0] len,
	output logic            out
);

	bmsg_pkg::bmsg_pwm_st_t q;
	bmsg_pkg::bmsg_pwm_st_t n;

	always_comb begin
		n = q;
		if (!run) begin
			// Phase restarts while muted, so each tone after a stop, gap or rest opens high
			n.cnt = 8'h00;
			n.out = 1'b0;
		end else if (tick) begin
			n.out = ({2'b00, len} >= q.cnt);
			n.cnt = (q.cnt >= period) ? 8'h00 : 8'(q.cnt + 8'h01);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign out = q.out;

endmodule // bmsg_pwm

`default_nettype wire

/* verilog/bmsg_top.sv */
// Buzzer melody sound generator: one-shot tone and melody player
`timescale 1ns/1ps
`default_nettype none

module bmsg_top #(
	parameter int unsigned SND_DIV = bmsg_pkg::SND_DIV
) (
	input  wire logic                          CLK,
	input  wire logic                          RST_B,
	input  wire logic [7:0]                    ADDR,
	input  wire logic [15:0]                   WDATA,
	input  wire logic                          WR,
	input  wire logic                          RD,
	output logic [15:0]                        RDATA,
	output logic                               BZ_OUT,
	output logic [bmsg_pkg::DMA_CH-1:0]        DMA_REQ
);

	localparam logic [bmsg_pkg::DIV_W-1:0] DIV_LAST =
		bmsg_pkg::DIV_W'(SND_DIV - 1);

	bmsg_pkg::bmsg_st_t q;
	bmsg_pkg::bmsg_st_t n;

	logic snd_tick;
	logic load;
	logic stop;
	logic expire;
	logic pwm_run;
	logic pwm_out;

	// Modes outside one-shot and melody never start the player
	function automatic logic mode_plays(input logic [1:0] m);
		return (m == bmsg_pkg::MODE_ONESHOT) ||
			(m == bmsg_pkg::MODE_MELODY);
	endfunction

	// Ticks a loaded word plays for, from mode and duration field, and in melody mode also the word's pulse_length
	function automatic logic [bmsg_pkg::TMR_W-1:0] play_ticks(
		input logic [1:0]          m,
		input logic [3:0]          sel,
		input bmsg_pkg::bmsg_word_t w
	);
		logic [bmsg_pkg::TMR_W-1:0] unit;
		logic [bmsg_pkg::TMR_W-1:0] notes;
		unit  = bmsg_pkg::TMR_W'(sel) + bmsg_pkg::TMR_W'(1);
		notes = bmsg_pkg::TMR_W'(w.pulse_length) + bmsg_pkg::TMR_W'(1);
		if (m == bmsg_pkg::MODE_MELODY) begin
			return bmsg_pkg::TMR_W'(unit * notes *
				bmsg_pkg::TMR_W'(bmsg_pkg::TEMPO_BASE));
		end
		return bmsg_pkg::TMR_W'(unit *
			bmsg_pkg::TMR_W'(bmsg_pkg::ONESHOT_BASE));
	endfunction

	function automatic logic addr_is(
		input logic [7:0] a,
		input logic [7:0] r
	);
		return a == r;
	endfunction

	// Tone shape follows the loaded word; gap and rest mute the pin
	assign pwm_run = (q.state == bmsg_pkg::ST_PLAY) &&
		!q.sound_reg.rest_select_bit && (q.gap == 5'h00);

	bmsg_pwm u_pwm (
		.clk    (CLK),
		.rst_b  (RST_B),
		.tick   (snd_tick),
		.run    (pwm_run),
		.period (q.sound_reg.freq_period),
		.len    (q.sound_reg.pulse_length),
		.out    (pwm_out)
	);

	always_comb begin
		n = q;
		n.rdata = 16'h0000;
		load = 1'b0;
		stop = 1'b0;

		// Sound clock enable
		snd_tick = (q.div == DIV_LAST);
		n.div = snd_tick ? '0 : bmsg_pkg::DIV_W'(q.div + 1'b1);

		expire = (q.tmr == bmsg_pkg::TMR_W'(1));

		if (snd_tick) begin
			unique case (q.state)
				bmsg_pkg::ST_IDLE: begin
					load = q.buf_full && mode_plays(q.output_mode_sel);
				end
				bmsg_pkg::ST_PLAY: begin
					if (expire) begin
						if (q.output_mode_sel == bmsg_pkg::MODE_MELODY &&
							q.buf_full) begin
							load = 1'b1;
						end else begin
							stop = 1'b1;
						end
					end else begin
						n.tmr = bmsg_pkg::TMR_W'(q.tmr - 1'b1);
					end
					if (q.gap != 5'h00) begin
						n.gap = 5'(q.gap - 5'h01);
					end
				end
			endcase
		end

		if (load) begin
			n.sound_reg = q.sound_buffer;
			n.buf_full = 1'b0;
			n.buffer_empty_flag = 1'b1;
			n.state = bmsg_pkg::ST_PLAY;
			n.tmr = play_ticks(q.output_mode_sel,
				q.duration_tempo_sel, q.sound_buffer);
			// A short mute opens each untied melody note so repeats are heard
			n.gap = (q.sound_buffer.tie_slur_bit ||
				q.output_mode_sel != bmsg_pkg::MODE_MELODY) ?
				5'h00 : bmsg_pkg::GAP_TICKS;
		end

		if (stop) begin
			n.state = bmsg_pkg::ST_IDLE;
			n.gap = 5'h00;
		end

		if (WR) begin
			if (addr_is(ADDR, bmsg_pkg::ADR_MODE)) begin
				n.output_mode_sel = WDATA[bmsg_pkg::MODE_LSB +: 2];
				n.duration_tempo_sel = WDATA[bmsg_pkg::DUR_LSB +: 4];
			end
			if (addr_is(ADDR, bmsg_pkg::ADR_BUF)) begin
				// Data written in the load cycle stays queued behind it
				n.sound_buffer = bmsg_pkg::bmsg_word_t'(WDATA);
				n.buf_full = 1'b1;
				n.buffer_empty_flag = 1'b0;
				if (!stop) begin
					n.output_done_flag = 1'b0;
				end
			end
			if (addr_is(ADDR, bmsg_pkg::ADR_FLAG)) begin
				if (WDATA[bmsg_pkg::FLG_DONE] && !stop) begin
					n.output_done_flag = 1'b0;
				end
			end
			if (addr_is(ADDR, bmsg_pkg::ADR_DMA)) begin
				n.empty_dma_enable_bit = WDATA[bmsg_pkg::DMA_CH-1:0];
			end
		end

		// Hardware set wins over a clear in the same cycle
		if (stop) begin
			n.output_done_flag = 1'b1;
		end

		if (RD) begin
			if (addr_is(ADDR, bmsg_pkg::ADR_MODE)) begin
				n.rdata[bmsg_pkg::MODE_LSB +: 2] = q.output_mode_sel;
				n.rdata[bmsg_pkg::DUR_LSB +: 4] = q.duration_tempo_sel;
			end
			if (addr_is(ADDR, bmsg_pkg::ADR_BUF)) begin
				n.rdata = 16'(q.sound_buffer);
			end
			if (addr_is(ADDR, bmsg_pkg::ADR_FLAG)) begin
				n.rdata[bmsg_pkg::FLG_EMPTY] = q.buffer_empty_flag;
				n.rdata[bmsg_pkg::FLG_DONE] = q.output_done_flag;
				n.rdata[bmsg_pkg::FLG_BUSY] =
					(q.state == bmsg_pkg::ST_PLAY);
			end
			if (addr_is(ADDR, bmsg_pkg::ADR_DMA)) begin
				n.rdata[bmsg_pkg::DMA_CH-1:0] = q.empty_dma_enable_bit;
			end
		end

		// Request holds while empty; the refill write drops it
		n.dma_req = n.empty_dma_enable_bit &
			{bmsg_pkg::DMA_CH{n.buffer_empty_flag}};

		n.bz = pwm_run && pwm_out;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			q <= '0;
			q.state <= bmsg_pkg::ST_IDLE;
			q.output_mode_sel <= bmsg_pkg::RST_MODE;
			q.buffer_empty_flag <= bmsg_pkg::RST_EMPTY;
		end else begin
			q <= n;
		end
	end

	assign RDATA = q.rdata;
	assign BZ_OUT = q.bz;
	assign DMA_REQ = q.dma_req;

endmodule // bmsg_top

`default_nettype wire

/* test/bmsg_chk.sv */
// Checker: port-level properties of the sound generator
`timescale 1ns/1ps
`default_nettype none
module bmsg_chk #(
	parameter int unsigned SND_DIV = 4
) (
	input wire logic                        CLK,
	input wire logic                        RST_B,
	input wire logic [7:0]                  ADDR,
	input wire logic [15:0]                 WDATA,
	input wire logic                        WR,
	input wire logic                        RD,
	input wire logic [15:0]                 RDATA,
	input wire logic                        BZ_OUT,
	input wire logic [bmsg_pkg::DMA_CH-1:0] DMA_REQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	logic wbuf, rflg;
	assign wbuf = WR && ADDR == bmsg_pkg::ADR_BUF;
	assign rflg = RD && ADDR == bmsg_pkg::ADR_FLAG;
	property p_rd_idle; !$past(RD) |-> RDATA == 16'h0000; endproperty
	property p_unmap; RD && ADDR == 8'h10 |=> RDATA == 16'h0000; endproperty
	property p_mode_rb;
		WR && ADDR == bmsg_pkg::ADR_MODE ##2 RD && ADDR == bmsg_pkg::ADR_MODE
		|=> RDATA[7:0] == ($past(WDATA[7:0], 3) & 8'hF3);
	endproperty
	property p_dma_mask;
		WR && ADDR == bmsg_pkg::ADR_DMA |=> (DMA_REQ & ~$past(WDATA[3:0])) == 4'h0;
	endproperty
	property p_buf_drop; wbuf |=> DMA_REQ == 4'h0; endproperty
	// Busy read low means the pin register saw an idle player
	property p_quiet; rflg ##1 !RDATA[2] |-> !BZ_OUT; endproperty
	// Pulse and space are whole sound ticks, never shorter than one
	property p_hi; $rose(BZ_OUT) |-> BZ_OUT [*4]; endproperty
	property p_lo; $fell(BZ_OUT) |-> !BZ_OUT [*4]; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	a_mode_rb: assert property (p_mode_rb)
		else $error("mode readback wrong");
	a_dma_mask: assert property (p_dma_mask)
		else $error("dma request on disabled channel");
	a_buf_drop: assert property (p_buf_drop)
		else $error("dma request after buffer write");
	a_quiet: assert property (p_quiet)
		else $error("pin active while idle");
	a_hi: assert property (p_hi)
		else $error("pulse too short");
	a_lo: assert property (p_lo)
		else $error("space too short");
	c_buf: cover property (wbuf);
	c_tone: cover property ($rose(BZ_OUT));
	c_dma: cover property (DMA_REQ != 4'h0);
endmodule // bmsg_chk
bind bmsg_top bmsg_chk #(.SND_DIV(SND_DIV)) u_chk (.CLK, .RST_B, .ADDR,
	.WDATA, .WR, .RD, .RDATA, .BZ_OUT, .DMA_REQ);
`default_nettype wire

/* test/bmsg_buzzer.sv */
// Buzzer model: counts tone pulses and high time on the pin
`timescale 1ns/1ps
`default_nettype none
module bmsg_buzzer (
	input  wire logic clk,
	input  wire logic pin,
	input  wire logic clr,
	output var int    rises,
	output var int    highs
);
	logic last_q;
	// A piezo load only reacts to edges and on-time
	always @(posedge clk) begin
		last_q <= pin;
		if (clr) begin
			rises <= 0;
			highs <= 0;
		end else begin
			rises <= rises + int'(pin && !last_q);
			highs <= highs + int'(pin);
		end
	end
endmodule // bmsg_buzzer
`default_nettype wire

/* test/testbench.sv */
// Bench: one-shot and melody sequences through the register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 0, rst_b = 0, wr = 0, rd = 0, clr = 1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, d;
	logic        bz;
	logic [3:0]  dma;
	int          rises, highs, miscompares = 0, total_checks = 0;
	bmsg_top #(.SND_DIV(4)) DUT (.CLK(clk), .RST_B(rst_b), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BZ_OUT(bz),
		.DMA_REQ(dma));
	bmsg_buzzer bz_m (.clk(clk), .pin(bz), .clr(clr), .rises(rises),
		.highs(highs));
	initial forever #20 clk = ~clk;
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic w(logic [7:0] a, logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic r(logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Polls the flag word; a stuck flag ends the run
	task automatic wf(int b, logic v);
		int i;
		r(8'h08);
		for (i = 0; i < 3000 && d[b] !== v; i++)
			r(8'h08);
		if (i == 3000) begin
			miscompares++;
			end_of_test();
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		clr <= 1'b0;
		r(8'h08);
		chk("flags", 16'h0001, d);
		w(8'h10, 16'hFFFF);
		r(8'h10);
		chk("unmapped", 16'h0000, d);
		r(8'h00);
		chk("mode", 16'h0000, d);
		$display("test reset done");
		w(8'h00, 16'h0001);
		w(8'h0C, 16'h0001);
		@(negedge clk);
		chk("dma", 16'h0001, {12'h000, dma});
		clr <= 1'b1;
		w(8'h04, 16'h0001);
		@(negedge clk);
		chk("dma", 16'h0000, {12'h000, dma});
		clr <= 1'b0;
		wf(2, 1'b1);
		chk("flags", 16'h0005, d);
		wf(2, 1'b0);
		chk("flags", 16'h0003, d);
		chk("pulses", 16'h0001, {15'h0, rises >= 127 && rises <= 128});
		chk("duty", 16'h0001, {15'h0, highs == 4 * rises});
		$display("test oneshot done");
		w(8'h00, 16'h0002);
		r(8'h00);
		chk("mode", 16'h0002, d);
		w(8'h04, 16'h0003);
		wf(0, 1'b1);
		chk("flags", 16'h0005, d);
		w(8'h04, 16'h4003);
		wf(0, 1'b1);
		repeat (8) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		// Well inside the 256-cycle rest at this tempo
		repeat (200) @(posedge clk);
		chk("rest", 16'h0000, rises[15:0]);
		w(8'h04, 16'h8003);
		wf(0, 1'b1);
		wf(2, 1'b0);
		chk("flags", 16'h0003, d);
		// An untied note would lose its first pulses to the mute gap
		chk("tied", 16'h0001, {15'h0, rises >= 15});
		w(8'h08, 16'h0002);
		r(8'h08);
		chk("flags", 16'h0001, d);
		@(negedge clk);
		chk("dma", 16'h0001, {12'h000, dma});
		$display("test melody done");
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
